// ---- hw/pbc_basic_regs.v ----
// Operation
// - writing one to control bit 15 resets the transceiver; bit self-clears
// - control bit 14 selects loopback; read/write, resets to zero
// - bit 13 forces 100 or 10 Mbps; ignored while autoneg enabled
// - bit 12 enables autoneg; negotiated result overrides forced speed, duplex
// - bit 11 powers down; first reset write only clears power-down
// - a full reset from power-down needs two reset writes; second resets, re-samples straps
// - bit 10 isolates transceiver from media-independent interface
// - writing one to bit 9 restarts autoneg; bit self-clears
// - bit 8 selects full duplex when set, half when clear
// - bit 7 enables collision test; resets to zero
// - forced speed reset value comes from rate strap
// - forced duplex reset value is inverse of line-mode strap
// - autoneg enable reset value comes from autoneg strap
// - isolate reset value comes from detach strap
// - status bit 15 reads zero, no T4 capability
// - status bit 14 reads one, 100 Mbps full duplex supported
`include "pbc_defs.vh"
`default_nettype none
module pbc_basic_regs (
  input wire clk_sys,
  input wire nrst,
  // register port from the management interface
  input wire [4:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regWdata,
  output reg [15:0] regRdata,
  output reg regRvalid,
  // strap pins
  input wire rateStrapPin,
  input wire lineModeStrapPin,
  input wire autoneg_strap_pin,
  input wire detachStrapPin,
  // negotiated outcome from the autoneg engine
  input wire anDone,
  input wire anSpeed100,
  input wire anFullDuplex,
  // control to the datapath
  output wire chipReset,
  output wire loopbackEn,
  output wire speed100,
  output wire fullDuplex,
  output wire anEnable,
  output reg anRestart,
  output wire powerDown,
  output wire miiIsolate,
  output wire colTestEn
);
  reg loop_ff;
  reg speed_ff;
  reg anEn_ff;
  reg pdown_ff;
  reg iso_ff;
  reg duplex_ff;
  reg colTst_ff;
  reg chipRstReq_ff;
  wire [3:0] strapVal;
  wire strapLoad;
  wire ctrlWr;
  wire rstWr;
  wire [15:0] ctrlWord;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture at power-on and on a full chip reset
  pbc_strap_latch uStrap (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .capture(chipRstReq_ff),
    .strapIn({rateStrapPin, lineModeStrapPin, autoneg_strap_pin, detachStrapPin}),
    .strapOut(strapVal),
    .strapValid(strapLoad)
  );

  // chip reset pulse for the rest of the transceiver
  pbc_pulse_gen uRstPulse (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .trigger(chipRstReq_ff),
    .pulse(chipReset)
  );

  assign ctrlWr = regWrite && (regAddr == `PBC_ADDR_CTRL);
  assign rstWr = ctrlWr && regWdata[`PBC_BIT_RESET];

  ////////////////////////////////////////////////////////////////////////////
  // control register; straps load after capture, writes otherwise
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      loop_ff <= `PBC_RST_LOOP;
      speed_ff <= 1'b0;
      anEn_ff <= 1'b0;
      pdown_ff <= `PBC_RST_PDOWN;
      iso_ff <= 1'b0;
      duplex_ff <= 1'b0;
      colTst_ff <= `PBC_RST_COLTST;
      chipRstReq_ff <= 1'b0;
      anRestart <= 1'b0;
    end else begin
      chipRstReq_ff <= 1'b0;
      anRestart <= 1'b0;
      if (strapLoad) begin
        // chip reset returns all fields to defaults
        loop_ff <= `PBC_RST_LOOP;
        pdown_ff <= `PBC_RST_PDOWN;
        colTst_ff <= `PBC_RST_COLTST;
        speed_ff <= strapVal[3];
        duplex_ff <= ~strapVal[2];
        anEn_ff <= strapVal[1];
        iso_ff <= strapVal[0];
      end else if (rstWr && pdown_ff) begin
        // first reset write while powered down only wakes the part
        pdown_ff <= 1'b0;
      end else if (rstWr) begin
        chipRstReq_ff <= 1'b1;
      end else if (ctrlWr) begin
        loop_ff <= regWdata[`PBC_BIT_LOOP];
        speed_ff <= regWdata[`PBC_BIT_SPEED];
        anEn_ff <= regWdata[`PBC_BIT_ANEN];
        pdown_ff <= regWdata[`PBC_BIT_PDOWN];
        iso_ff <= regWdata[`PBC_BIT_ISO];
        duplex_ff <= regWdata[`PBC_BIT_DUPLEX];
        colTst_ff <= regWdata[`PBC_BIT_COLTST];
        anRestart <= regWdata[`PBC_BIT_ANRST];
      end
    end
  end

  // self-clearing bits 15 and 9 always read back zero
  assign ctrlWord = {1'b0, loop_ff, speed_ff, anEn_ff, pdown_ff, iso_ff,
                     1'b0, duplex_ff, colTst_ff, 7'h00};

  ////////////////////////////////////////////////////////////////////////////
  // read data registered, one cycle after the read strobe
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 16'h0000;
      regRvalid <= 1'b0;
    end else begin
      regRvalid <= regRead;
      if (regRead) begin
        case (regAddr)
          `PBC_ADDR_CTRL: regRdata <= ctrlWord;
          `PBC_ADDR_STAT: regRdata <= `PBC_STAT_VALUE;
          default: regRdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective mode: negotiated result wins while autoneg is on
  assign anEnable = anEn_ff;
  assign speed100 = anEn_ff ? (anDone & anSpeed100) : speed_ff;
  assign fullDuplex = anEn_ff ? (anDone & anFullDuplex) : duplex_ff;
  assign loopbackEn = loop_ff;
  assign powerDown = pdown_ff;
  assign miiIsolate = iso_ff;
  assign colTestEn = colTst_ff;
endmodule // pbc_basic_regs
`default_nettype wire

// ---- hw/pbc_defs.vh ----
`ifndef PBC_DEFS_VH
`define PBC_DEFS_VH
// register indices on the management register port
`define PBC_ADDR_CTRL 5'h00
`define PBC_ADDR_STAT 5'h01
// control bit positions
`define PBC_BIT_RESET 15
`define PBC_BIT_LOOP 14
`define PBC_BIT_SPEED 13
`define PBC_BIT_ANEN 12
`define PBC_BIT_PDOWN 11
`define PBC_BIT_ISO 10
`define PBC_BIT_ANRST 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COLTST 7
// reset values of the plain control bits
`define PBC_RST_LOOP 1'b0
`define PBC_RST_PDOWN 1'b0
`define PBC_RST_COLTST 1'b0
// status word: only the top two capability bits are modelled
`define PBC_STAT_VALUE 16'h4000
// length of the internal chip-reset pulse in clocks
`define PBC_CHIP_RST_CYCLES 4'h4
`endif

// ---- hw/pbc_pulse_gen.v ----
`include "pbc_defs.vh"
`default_nettype none
// stretches a one-cycle trigger into a fixed-length pulse
module pbc_pulse_gen (
  input wire clk_sys,
  input wire nrst,
  input wire trigger,
  output wire pulse
);
  reg [3:0] count_ff;
  ////////////////////////////////////////////////////////////////////////////
  // load on trigger, count down to zero
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_ff <= 4'h0;
    end else if (trigger) begin
      count_ff <= `PBC_CHIP_RST_CYCLES;
    end else if (count_ff != 4'h0) begin
      count_ff <= count_ff - 4'h1;
    end
  end
  assign pulse = (count_ff != 4'h0);
endmodule // pbc_pulse_gen
`default_nettype wire

// ---- hw/pbc_strap_latch.v ----
`default_nettype none
// strap capture: takes the strap levels on the first edge after a reset request
module pbc_strap_latch (
  input wire clk_sys,
  input wire nrst,
  input wire capture,
  input wire [3:0] strapIn,
  output reg [3:0] strapOut,
  output reg strapValid
);
  reg pending_ff;
  ////////////////////////////////////////////////////////////////////////////
  // async reset loads constants only; pins are caught after the release
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pending_ff <= 1'b1;
      strapOut <= 4'h0;
      strapValid <= 1'b0;
    end else begin
      strapValid <= 1'b0;
      if (pending_ff || capture) begin
        strapOut <= strapIn;
        strapValid <= 1'b1;
        pending_ff <= 1'b0;
      end
    end
  end
endmodule // pbc_strap_latch
`default_nettype wire

// ---- verif/pbc_an_model.sv ----
`default_nettype none
// autoneg stand-in: result drops on restart, settles after LAT cycles
module pbc_an_model #(parameter int LAT = 20) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic anRestart,
  output logic anDone,
  output logic anSpeed100,
  output logic anFullDuplex
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // count down while negotiating
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) cnt <= 0;
    else if (anRestart) cnt <= LAT;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // busy outcome lines toggle so ungated use shows
  assign anDone = cnt == 0;
  assign anSpeed100 = anDone | cnt[0];
  assign anFullDuplex = anDone | ~cnt[0];
endmodule // pbc_an_model
`default_nettype wire

// ---- verif/pbc_basic_regs_checker.sv ----
`default_nettype none
module pbc_basic_regs_checker (
  input wire logic clk_sys, nrst, regWrite, regRead, regRvalid, anDone, anSpeed100,
  input wire logic anFullDuplex, chipReset, loopbackEn, speed100, fullDuplex, anEnable,
  input wire logic anRestart, powerDown, miiIsolate, colTestEn,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata, regRdata
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // control writes; a bit 15 write loads no field from the data
  wire logic rw = regWrite && regAddr == 5'h00;
  wire logic wf = rw && !regWdata[15];
  ////////////////////////////////////////
  // one decode cycle, then a four-cycle chip reset
  sequence s_pulse; !chipReset ##1 chipReset [*4] ##1 !chipReset; endsequence
  sequence s_quiet; (!powerDown && !chipReset) [*4]; endsequence
  property p_sr; rw && regWdata[15] && !powerDown |=> s_pulse; endproperty
  a_sr: assert property (p_sr) else $error("bad chip reset");
  property p_pd; rw && regWdata[15] && powerDown |=> s_quiet; endproperty
  a_pd: assert property (p_pd) else $error("bad power-down exit");
  property p_wr; wf |=> {loopbackEn, anEnable, powerDown, miiIsolate, colTestEn} ==
    $past({regWdata[14], regWdata[12:10], regWdata[7]}); endproperty
  a_wr: assert property (p_wr) else $error("bad field");
  property p_fs; wf && !regWdata[12] |=> {speed100, fullDuplex} ==
    $past({regWdata[13], regWdata[8]}); endproperty
  a_fs: assert property (p_fs) else $error("bad forced mode");
  property p_an; anEnable |-> {speed100, fullDuplex} ==
    {anDone & anSpeed100, anDone & anFullDuplex}; endproperty
  a_an: assert property (p_an) else $error("bad autoneg mode");
  property p_ar; wf && regWdata[9] |=> anRestart ##1 !anRestart; endproperty
  a_ar: assert property (p_ar) else $error("bad restart");
  property p_st; regRead && regAddr == 5'h01 |=> regRvalid && regRdata == 16'h4000; endproperty
  a_st: assert property (p_st) else $error("bad status");
  property p_rs; regRvalid |-> regRdata[6:0] == 7'h00 && !regRdata[15] && !regRdata[9];
  endproperty
  a_rs: assert property (p_rs) else $error("bad zero bits");
endmodule // pbc_basic_regs_checker
bind pbc_basic_regs pbc_basic_regs_checker chk_u (.*);
`default_nettype wire

// ---- verif/pbc_basic_regs_tb.sv ----
`default_nettype none
module pbc_basic_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, nrst = 0, regWrite = 0, regRead = 0;
  logic rateStrapPin = 1, lineModeStrapPin = 0, autoneg_strap_pin = 0, detachStrapPin = 1;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  wire logic [15:0] regRdata;
  wire logic regRvalid, anDone, anSpeed100, anFullDuplex, chipReset, loopbackEn, speed100;
  wire logic fullDuplex, anEnable, anRestart, powerDown, miiIsolate, colTestEn;
  int err_total = 0, samples_checked = 0;
  pbc_basic_regs dut_u (.*);
  pbc_an_model an_u (.*);
  // 10 MHz clock
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task end_of_test;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobe; the idle gap outlasts a chip reset
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWdata = d;
    regWrite = 1;
    @(negedge clk_sys);
    regWrite = 0;
    repeat (6) @(negedge clk_sys);
  endtask
  task rd(input logic [4:0] a, input logic [15:0] exp);
    int i;
    @(negedge clk_sys);
    regAddr = a;
    regRead = 1;
    @(negedge clk_sys);
    regRead = 0;
    for (i = 0; i < 3 && regRvalid !== 1'b1; i++) @(negedge clk_sys);
    if (i == 3) begin
      err_total++;
      $display("[ERR] %0t read timeout", $time);
      end_of_test;
    end else chk(regRdata, exp);
  endtask
  ////////////////////////////////////////
  task t_rw;
    rd(5'h00, 16'h2500);
    wr(5'h00, 16'h4dff);
    rd(5'h00, 16'h4d80);
    chk({12'h000, loopbackEn, powerDown, miiIsolate, colTestEn}, 16'h000f);
    wr(5'h00, 16'h0200);
    rd(5'h00, 16'h0000);
    $display("read write done");
  endtask
  // forced bits set while negotiating must not leak out
  task t_an;
    int i;
    wr(5'h00, 16'h3300);
    chk({14'h0000, speed100, fullDuplex}, 16'h0000);
    for (i = 0; i < 40 && anDone !== 1'b1; i++) @(negedge clk_sys);
    if (i == 40) begin
      err_total++;
      $display("[ERR] %0t autoneg timeout", $time);
      end_of_test;
    end
    chk({14'h0000, speed100, fullDuplex}, 16'h0003);
    rd(5'h00, 16'h3100);
    $display("autoneg done");
  endtask
  task t_pd;
    wr(5'h00, 16'h0800);
    {rateStrapPin, lineModeStrapPin, autoneg_strap_pin, detachStrapPin} = 4'h0;
    wr(5'h00, 16'h8000);
    rd(5'h00, 16'h0000);
    wr(5'h00, 16'h8000);
    rd(5'h00, 16'h0100);
    wr(5'h01, 16'hffff);
    rd(5'h01, 16'h4000);
    rd(5'h07, 16'h0000);
    $display("power-down status done");
  endtask
  initial begin
    #300 nrst = 1;
    repeat (2) @(negedge clk_sys);
    t_rw;
    t_an;
    t_pd;
    end_of_test;
  end
endmodule // pbc_basic_regs_tb
`default_nettype wire
